/* hw/uoi_flags.sv */
// usb otg / device interrupt flags, enables and apb register slave
`timescale 1ns/1ns
// Contract
// [RULE1] set b-session-end flag when vbus crosses b session end either way
// [RULE2] set a-supply-valid flag when vbus crosses the a vbus valid threshold
// [RULE3] otg enable register: each one bit enables its otg status interrupt
// [RULE4] flags are sticky; a written one clears exactly that flag
// [RULE5] software must not clear flags with read-modify-write operations
// [RULE6] set stall flag when a stall handshake has been sent
// [RULE7] set resume flag after k-state held 2.5 us; k depends on speed
// [RULE8] set idle flag after a constant idle state of 3 ms
// [RULE9] set token flag when token processing completes
// [RULE10] clearing token flag advances the transfer status fifo
// [RULE11] set frame-start flag on sof token or host sof threshold
// [RULE12] error flag set only by errors enabled in error enable register
// [RULE13] bus reset flag after 2.5 us reset; rearms after reset ends
// [RULE14] line-stable flag after 1 ms stable state differing from the last
// [RULE15] only the low byte of each register exists; upper bits read zero
// [RULE16] interrupt request while any flag and its enable are both set
module uoi_flags
	import uoi_pkg::*;
#(
	parameter int IDLE_CYCLES    = IDLE_CYC,
	parameter int LSTABLE_CYCLES = LSTABLE_CYC,
	parameter int MSEC_CYCLES    = MSEC_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              vbus_b_sess_end_in,
	input  wire logic              vbus_a_valid_in,
	input  wire logic              sess_valid_in,
	input  wire logic              id_in,
	input  wire logic              dp_in,
	input  wire logic              dm_in,
	input  wire logic              low_speed,
	input  wire logic              stall_sent,
	input  wire logic              token_done,
	input  wire logic              frame_start,
	input  wire logic [7:0]        err_events,
	output logic                   fifo_advance,
	output logic                   irq
);
	// synchronised pins: {dm, dp, id, sess, a_valid, b_end}
	logic [5:0] pin_lvl, pin_chg;
	uoi_sync #(.WIDTH(6)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({dm_in, dp_in, id_in, sess_valid_in, vbus_a_valid_in,
			vbus_b_sess_end_in}),
		.level    (pin_lvl),
		.change   (pin_chg)
	);

	logic dp_s, dm_s;
	assign dp_s = pin_lvl[4];
	assign dm_s = pin_lvl[5];

	// line decode: k is d+ high at low speed, d- high at full speed
	logic se0, k_state, j_state;
	assign se0     = !dp_s && !dm_s;
	assign k_state = low_speed ? (dp_s && !dm_s) : (dm_s && !dp_s); // RULE7
	assign j_state = low_speed ? (dm_s && !dp_s) : (dp_s && !dm_s);

	// duration detectors
	logic resume_hit, reset_hit, idle_hit, lstable_hit, msec_hit, msec_q;
	logic [1:0] line_now;
	logic [1:0] line_prev_q, line_last_q;
	assign line_now = {se0, j_state};

	uoi_hold_timer #(.CYCLES(RESUME_CYC)) u_resume (
		.pclk    (pclk),
		.presetn (presetn),
		.cond    (k_state),
		.hit     (resume_hit)
	);
	// fires once per reset, so the flag cannot re-arm until se0 ends
	uoi_hold_timer #(.CYCLES(BUS_RESET_CYC)) u_reset (
		.pclk    (pclk),
		.presetn (presetn),
		.cond    (se0),
		.hit     (reset_hit)
	);
	uoi_hold_timer #(.CYCLES(IDLE_CYCLES)) u_idle (
		.pclk    (pclk),
		.presetn (presetn),
		.cond    (j_state),
		.hit     (idle_hit)
	);
	uoi_hold_timer #(.CYCLES(LSTABLE_CYCLES)) u_lstable (
		.pclk    (pclk),
		.presetn (presetn),
		.cond    (line_now == line_prev_q),
		.hit     (lstable_hit)
	);
	// free-running tick: restarts the cycle after each hit
	uoi_hold_timer #(.CYCLES(MSEC_CYCLES)) u_msec (
		.pclk    (pclk),
		.presetn (presetn),
		.cond    (!msec_q),
		.hit     (msec_hit)
	);

	// line state history for the stable-change test
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_prev_q <= 2'h0;
			line_last_q <= 2'h0;
			msec_q      <= 1'b0;
		end else begin
			line_prev_q <= line_now;
			msec_q      <= msec_hit;
			if (lstable_hit) line_last_q <= line_now;
		end
	end

	// apb decode; slave always ready, so every transfer ends in one access cycle
	logic [IDX_W-1:0] idx;
	logic aligned, hit_otg_stat, hit_otg_en, hit_bus_stat, hit_bus_en, hit_err_en;
	logic mapped, access, wr;
	assign idx          = paddr[IDX_W+1:2];
	assign aligned      = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_W+2] == '0);
	assign hit_otg_stat = aligned && (idx == OTG_STAT_IDX);
	assign hit_otg_en   = aligned && (idx == OTG_EN_IDX);
	assign hit_bus_stat = aligned && (idx == BUS_STAT_IDX);
	assign hit_bus_en   = aligned && (idx == BUS_EN_IDX);
	assign hit_err_en   = aligned && (idx == ERR_EN_IDX);
	assign mapped  = hit_otg_stat | hit_otg_en | hit_bus_stat | hit_bus_en | hit_err_en;
	assign access  = psel && penable;
	assign wr      = access && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// event vectors in register layout
	logic [7:0] otg_set, bus_set, otg_clr, bus_clr;
	logic [7:0] otg_stat_q, otg_en_q, bus_stat_q, bus_en_q, err_en_q;
	logic [7:0] otg_stat_d, bus_stat_d;
	logic       err_hit;
	assign err_hit = |(err_events & err_en_q); // RULE12

	always_comb begin
		otg_set              = 8'h00;
		otg_set[OTG_A_VALID] = pin_chg[1];                     // RULE2
		otg_set[OTG_B_END]   = pin_chg[0];                     // RULE1
		otg_set[OTG_SESS]    = pin_chg[2];
		otg_set[OTG_ACTV]    = |{pin_chg[5:4], pin_chg[2:0]};
		otg_set[OTG_LSTABLE] = lstable_hit && (line_now != line_last_q); // RULE14
		otg_set[OTG_MSEC]    = msec_hit;
		otg_set[OTG_ID]      = pin_chg[3];
		bus_set              = 8'h00;
		bus_set[BUS_RESET]   = reset_hit;                      // RULE13
		bus_set[BUS_ERR]     = err_hit;                        // RULE12
		bus_set[BUS_SOF]     = frame_start;                    // RULE11
		bus_set[BUS_TOKEN]   = token_done;                     // RULE9
		bus_set[BUS_IDLE]    = idle_hit;                       // RULE8
		bus_set[BUS_RESUME]  = resume_hit;                     // RULE7
		bus_set[BUS_STALL]   = stall_sent;                     // RULE6
	end

	// clear only the bits written with one; a same-cycle set beats the clear
	assign otg_clr    = (wr && hit_otg_stat) ? pwdata[7:0] : 8'h00; // RULE4
	assign bus_clr    = (wr && hit_bus_stat) ? pwdata[7:0] : 8'h00; // RULE4
	assign otg_stat_d = ((otg_stat_q & ~otg_clr) | otg_set) & OTG_IMPL;
	assign bus_stat_d = ((bus_stat_q & ~bus_clr) | bus_set) & BUS_IMPL;

	// status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otg_stat_q <= REG_RESET;
			bus_stat_q <= REG_RESET;
		end else begin
			otg_stat_q <= otg_stat_d; // RULE1 RULE2
			bus_stat_q <= bus_stat_d; // RULE6
		end
	end

	// software enables; only the low byte is stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otg_en_q <= REG_RESET;
			bus_en_q <= REG_RESET;
			err_en_q <= REG_RESET;
		end else if (wr) begin
			if (hit_otg_en) otg_en_q <= pwdata[7:0] & OTG_IMPL; // RULE3 RULE15
			if (hit_bus_en) bus_en_q <= pwdata[7:0] & BUS_IMPL;
			if (hit_err_en) err_en_q <= pwdata[7:0];
		end
	end

	// fifo step when a set token flag is cleared by software
	logic fifo_adv_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_adv_q <= 1'b0;
		end else begin
			fifo_adv_q <= bus_clr[BUS_TOKEN] && bus_stat_q[BUS_TOKEN]; // RULE10
		end
	end
	assign fifo_advance = fifo_adv_q;

	// one level interrupt; registered to keep the pin glitch free
	logic irq_q;
	logic irq_any;
	assign irq_any = |(otg_stat_q & otg_en_q) || |(bus_stat_q & bus_en_q); // RULE16
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_any;
		end
	end
	assign irq = irq_q;

	// read mux; data captured in the setup cycle, upper bits read zero
	logic [7:0]  rd_sel;
	logic [31:0] prdata_q;
	assign rd_sel = hit_otg_stat ? otg_stat_q :
		hit_otg_en   ? otg_en_q :
		hit_bus_stat ? bus_stat_q :
		hit_bus_en   ? bus_en_q :
		hit_err_en   ? err_en_q : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_q <= {24'h00_0000, rd_sel}; // RULE15
		end
	end
	assign prdata = prdata_q;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_stall_sets: assert property (stall_sent |=> bus_stat_q[BUS_STALL]) // RULE6
		else $error("stall event did not set its flag");

	a_b_end_sets: assert property (pin_chg[0] |=> otg_stat_q[OTG_B_END]) // RULE1
		else $error("b session end crossing did not set its flag");

	a_a_valid_sets: assert property (pin_chg[1] |=> otg_stat_q[OTG_A_VALID]) // RULE2
		else $error("a vbus valid crossing did not set its flag");

	a_w1c_exact: assert property (wr && hit_bus_stat && !pwdata[BUS_STALL] // RULE4
		&& bus_stat_q[BUS_STALL] |=> bus_stat_q[BUS_STALL])
		else $error("flag cleared without a written one");

	a_w1c_clears: assert property (wr && hit_bus_stat && pwdata[BUS_STALL] // RULE4
		&& !stall_sent |=> !bus_stat_q[BUS_STALL])
		else $error("written one did not clear its flag");

	a_set_beats_clr: assert property (token_done && wr && hit_bus_stat // RULE9
		&& pwdata[BUS_TOKEN] |=> bus_stat_q[BUS_TOKEN])
		else $error("token event lost against a clear");

	a_token_sets: assert property (token_done |=> bus_stat_q[BUS_TOKEN]) // RULE9
		else $error("token event did not set its flag");

	a_sof_sets: assert property (frame_start |=> bus_stat_q[BUS_SOF]) // RULE11
		else $error("frame start did not set its flag");

	a_resume_sets: assert property (resume_hit |=> bus_stat_q[BUS_RESUME]) // RULE7
		else $error("resume detection did not set its flag");

	a_idle_sets: assert property (idle_hit |=> bus_stat_q[BUS_IDLE]) // RULE8
		else $error("idle detection did not set its flag");

	a_reset_sets: assert property (reset_hit |=> bus_stat_q[BUS_RESET]) // RULE13
		else $error("bus reset detection did not set its flag");

	a_fifo_step: assert property (wr && hit_bus_stat && pwdata[BUS_TOKEN] // RULE10
		&& bus_stat_q[BUS_TOKEN] |=> fifo_advance ##1 !fifo_advance)
		else $error("fifo did not advance once on token clear");

	a_err_masked: assert property (!bus_stat_q[BUS_ERR] && !(wr && hit_bus_stat) // RULE12
		&& !err_hit |=> !bus_stat_q[BUS_ERR])
		else $error("masked error set the error flag");

	a_otg_gate: assert property ((otg_stat_q & otg_en_q) == 8'h00 // RULE3
		&& (bus_stat_q & bus_en_q) == 8'h00 |=> !irq)
		else $error("interrupt raised with nothing enabled");

	a_irq_follow: assert property (irq_any |=> irq) // RULE16
		else $error("enabled flag did not raise the interrupt");

	a_irq_raise: assert property ($rose(irq) |-> $past(irq_any)) // RULE16
		else $error("interrupt rose without an enabled flag");

	a_upper_zero: assert property (access && !pwrite |-> prdata[31:8] == 24'h00_0000) // RULE15
		else $error("upper read bits not zero");

	a_lstable_new: assert property (otg_set[OTG_LSTABLE] |-> line_now != line_last_q) // RULE14
		else $error("line stable flagged for an unchanged state");

	c_stall_irq: cover property (stall_sent && bus_en_q[BUS_STALL] ##2 irq);
	c_token_clear: cover property (token_done ##[1:20] fifo_advance);
	c_bus_reset: cover property (reset_hit ##1 bus_stat_q[BUS_RESET]);
	c_unmapped: cover property (pslverr);
endmodule

/* hw/uoi_hold_timer.sv */
// pulses once when a condition has held for CYCLES consecutive clocks
`timescale 1ns/1ns
module uoi_hold_timer #(
	parameter int CYCLES = 16
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic cond,
	output logic      hit
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	localparam logic [W-1:0] FULL = W'(CYCLES);
	logic [W-1:0] cnt_q;

	// saturate after the hit so one long hold gives a single pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (!cond) begin
			cnt_q <= '0;
		end else if (cnt_q != FULL) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign hit = cond && (cnt_q == LAST);
endmodule

/* hw/uoi_sync.sv */
// three-stage synchroniser with agreement filter and change pulse, per bit
`timescale 1ns/1ns
module uoi_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] change
);
	// the stages hold reset zeros, so until the pipe has filled the level is
	// loaded without a change pulse; a pin that idles high gives no false event
	logic [1:0] fill_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_q <= 2'h0;
		end else if (!(&fill_q)) begin
			fill_q <= fill_q + 2'h1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_q, s2_q, s3_q, lvl_q, chg_q;
			// s1 feeds only s2, so metastability never reaches logic
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					lvl_q <= 1'b0;
					chg_q <= 1'b0;
				end else begin
					s1_q  <= async_in[i];
					s2_q  <= s1_q;
					s3_q  <= s2_q;
					if (!(&fill_q)) begin
						chg_q <= 1'b0;
						lvl_q <= s2_q; // preload the real pin level
					end else begin
						chg_q <= (s2_q == s3_q) && (s3_q != lvl_q);
						if (s2_q == s3_q) lvl_q <= s3_q; // change counts when stages agree
					end
				end
			end
			assign level[i]  = lvl_q;
			assign change[i] = chg_q;
		end
	endgenerate
endmodule

/* shared/uoi_pkg.sv */
// shared constants for the usb otg interrupt flag block
package uoi_pkg;
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int IDX_W  = 12;
	// printed register offsets, used as word indices (byte address = 4 * index)
	localparam logic [IDX_W-1:0] OTG_STAT_IDX = 12'h600;
	localparam logic [IDX_W-1:0] OTG_EN_IDX   = 12'h602;
	localparam logic [IDX_W-1:0] BUS_STAT_IDX = 12'h60A;
	localparam logic [IDX_W-1:0] BUS_EN_IDX   = 12'h60C;
	localparam logic [IDX_W-1:0] ERR_EN_IDX   = 12'h60E;
	// otg status / enable bit positions
	localparam int OTG_A_VALID = 0;
	localparam int OTG_B_END   = 2;
	localparam int OTG_SESS    = 3;
	localparam int OTG_ACTV    = 4;
	localparam int OTG_LSTABLE = 5;
	localparam int OTG_MSEC    = 6;
	localparam int OTG_ID      = 7;
	localparam logic [7:0] OTG_IMPL = 8'hFD;
	// device-mode bus status bit positions
	localparam int BUS_RESET  = 0;
	localparam int BUS_ERR    = 1;
	localparam int BUS_SOF    = 2;
	localparam int BUS_TOKEN  = 3;
	localparam int BUS_IDLE   = 4;
	localparam int BUS_RESUME = 5;
	localparam int BUS_STALL  = 7;
	localparam logic [7:0] BUS_IMPL = 8'hBF;
	localparam logic [7:0] REG_RESET = 8'h00;
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int RESUME_NS     = 2500;
	localparam int BUS_RESET_NS  = 2500;
	localparam int IDLE_US       = 3000;
	localparam int LSTABLE_US    = 1000;
	localparam int MSEC_US       = 1000;
	localparam int RESUME_CYC    = (RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_RESET_CYC = (BUS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_CYC      = (IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LSTABLE_CYC   = (LSTABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MSEC_CYC      = (MSEC_US * 1000) / CLK_PERIOD_NS;
endpackage

/* tb/uoi_cable.sv */
// cable-side partner model: drives bus supply comparators, id and data line levels
`timescale 1ns/1ns
module uoi_cable (
	input  wire logic pclk,
	output logic      dp_out,
	output logic      dm_out,
	output logic      b_end_out,
	output logic      a_valid_out,
	output logic      sess_out,
	output logic      id_out
);
	// cable starts in full-speed j so that no bus reset is seen after power-up
	initial begin
		dp_out      = 1'h1;
		dm_out      = 1'h0;
		b_end_out   = 1'h0;
		a_valid_out = 1'h0;
		sess_out    = 1'h0;
		id_out      = 1'h0;
	end

	// hold a line state for n clocks; lines only move just after an edge
	task automatic line(input logic p, input logic m, input int n);
		@(posedge pclk);
		dp_out <= p;
		dm_out <= m;
		repeat (n) @(posedge pclk);
	endtask

	// supply comparator and id levels as a real cable would present them
	task automatic vbus(input logic b, input logic a, input logic s, input logic i);
		@(posedge pclk);
		b_end_out   <= b;
		a_valid_out <= a;
		sess_out    <= s;
		id_out      <= i;
	endtask
endmodule

/* tb/usb_otg_interrupt_flags_bench.sv */
// self-checking bench for the usb otg interrupt flag block
`timescale 1ns/1ns
module usb_otg_interrupt_flags_bench
	import uoi_pkg::*;
;
	localparam logic [15:0] A_OTG   = {2'h0, OTG_STAT_IDX, 2'h0};
	localparam logic [15:0] A_OTGEN = {2'h0, OTG_EN_IDX, 2'h0};
	localparam logic [15:0] A_BUS   = {2'h0, BUS_STAT_IDX, 2'h0};
	localparam logic [15:0] A_BUSEN = {2'h0, BUS_EN_IDX, 2'h0};
	localparam logic [15:0] A_ERREN = {2'h0, ERR_EN_IDX, 2'h0};
	localparam logic [15:0] A_BAD   = 16'h1804;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic              low_speed, stall_sent, token_done, frame_start, fifo_advance, irq;
	logic              dp, dm, b_end, a_valid, sess, id;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rdata;
	logic [7:0]        err_events;
	int                err_total, total_checks;

	// free-running clock at the block rate
	initial pclk = 1'h0;
	always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

	// timers shortened so the long counts fit in a short run
	uoi_flags #(.IDLE_CYCLES(50), .LSTABLE_CYCLES(40), .MSEC_CYCLES(30)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vbus_b_sess_end_in(b_end), .vbus_a_valid_in(a_valid), .sess_valid_in(sess),
		.id_in(id), .dp_in(dp), .dm_in(dm), .low_speed(low_speed), .stall_sent(stall_sent),
		.token_done(token_done), .frame_start(frame_start), .err_events(err_events),
		.fifo_advance(fifo_advance), .irq(irq));

	uoi_cable i_cable (.pclk(pclk), .dp_out(dp), .dm_out(dm), .b_end_out(b_end),
		.a_valid_out(a_valid), .sess_out(sess), .id_out(id));

	task automatic summarize;
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) err_total++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic rd(input logic [15:0] a);
		apb(1'h0, a, 32'h0);
	endtask

	// whole-word clear of every flag, never a read-modify-write
	task automatic clear_all;
		wr(A_OTG, 32'hFF);
		wr(A_BUS, 32'hFF);
	endtask

	task automatic pulse_err(input logic [7:0] v);
		@(posedge pclk);
		err_events <= v;
		@(posedge pclk);
		err_events <= 8'h0;
	endtask

	// reset values, implemented bits of the otg and bus enable registers, unmapped access
	task automatic t_regs;
		rd(A_OTGEN);
		check(rdata, 32'h0);
		rd(A_BUSEN);
		check(rdata, 32'h0);
		wr(A_OTGEN, 32'hFFFFFFFF);
		rd(A_OTGEN);
		check(rdata, {24'h0, OTG_IMPL});
		wr(A_BUSEN, 32'hFFFFFFFF);
		rd(A_BUSEN);
		check(rdata, {24'h0, BUS_IMPL});
		wr(A_BUSEN, 32'h0);
		wr(A_OTGEN, 32'h0);
		rd(A_BAD);
		check({rdata[31:1], rerr}, 32'h1);
	endtask

	// b session end crossings in both directions, a vbus valid rising crossing, exact clear of one flag
	task automatic t_vbus;
		clear_all();
		i_cable.vbus(1'h1, 1'h0, 1'h0, 1'h0);
		repeat (8) @(posedge pclk);
		rd(A_OTG);
		check(rdata & 32'h05, 32'h04);
		wr(A_OTG, 32'h04);
		rd(A_OTG);
		check(rdata & 32'h14, 32'h10);
		i_cable.vbus(1'h0, 1'h1, 1'h0, 1'h0);
		repeat (8) @(posedge pclk);
		rd(A_OTG);
		check(rdata & 32'h05, 32'h05);
	endtask

	// interrupt output follows flag and enable, both register groups
	task automatic t_irq;
		clear_all();
		@(posedge pclk);
		stall_sent <= 1'h1;
		@(posedge pclk);
		stall_sent <= 1'h0;
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		wr(A_BUSEN, 32'h80);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		wr(A_BUSEN, 32'h0);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		wr(A_OTGEN, 32'h80);
		i_cable.vbus(1'h0, 1'h1, 1'h0, 1'h1);
		repeat (8) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		wr(A_OTG, 32'h80);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		wr(A_OTGEN, 32'h0);
	endtask

	// same-clock events, zero write keeps flags, token clear advances the fifo
	task automatic t_bus;
		clear_all();
		@(posedge pclk);
		stall_sent <= 1'h1;
		token_done <= 1'h1;
		frame_start <= 1'h1;
		@(posedge pclk);
		stall_sent <= 1'h0;
		token_done <= 1'h0;
		frame_start <= 1'h0;
		rd(A_BUS);
		check(rdata & 32'h80, 32'h80);
		check(rdata & 32'h08, 32'h08);
		check(rdata & 32'h04, 32'h04);
		wr(A_BUS, 32'h0);
		rd(A_BUS);
		check(rdata & 32'h8C, 32'h8C);
		wr(A_BUS, 32'h08);
		#1;
		check({31'h0, fifo_advance}, 32'h1);
		@(posedge pclk);
		#1;
		check({31'h0, fifo_advance}, 32'h0);
		rd(A_BUS);
		check(rdata & 32'h8C, 32'h84);
		// a token event in the very cycle of its clear keeps the flag
		@(posedge pclk);
		token_done <= 1'h1;
		wr(A_BUS, 32'h08);
		token_done <= 1'h0;
		rd(A_BUS);
		check(rdata & 32'h08, 32'h08);
	endtask

	// only errors enabled in the error enable register raise the summary flag
	task automatic t_err;
		clear_all();
		pulse_err(8'hFF);
		rd(A_BUS);
		check(rdata & 32'h02, 32'h0);
		wr(A_ERREN, 32'h04);
		rd(A_ERREN);
		check(rdata, 32'h04);
		pulse_err(8'h02);
		rd(A_BUS);
		check(rdata & 32'h02, 32'h0);
		pulse_err(8'h04);
		rd(A_BUS);
		check(rdata & 32'h02, 32'h02);
	endtask

	// line timers: resume at both speeds, idle, one bus reset pulse per held se0, line stable
	task automatic t_line;
		clear_all();
		i_cable.line(1'h0, 1'h1, 330);
		i_cable.line(1'h1, 1'h0, 0);
		rd(A_BUS);
		check(rdata & 32'h20, 32'h20);
		wr(A_BUS, 32'h20);
		i_cable.line(1'h0, 1'h1, 290);
		i_cable.line(1'h1, 1'h0, 0);
		rd(A_BUS);
		check(rdata & 32'h20, 32'h0);
		wr(A_BUS, 32'h20);
		@(posedge pclk);
		low_speed <= 1'h1;
		i_cable.line(1'h1, 1'h0, 330);
		rd(A_BUS);
		check(rdata & 32'h20, 32'h20);
		@(posedge pclk);
		low_speed <= 1'h0;
		wr(A_BUS, 32'hFF);
		i_cable.line(1'h1, 1'h0, 60);
		rd(A_BUS);
		check(rdata & 32'h10, 32'h10);
		wr(A_BUS, 32'hFF);
		i_cable.line(1'h0, 1'h0, 330);
		rd(A_BUS);
		check(rdata & 32'h01, 32'h01);
		wr(A_BUS, 32'h01);
		wr(A_OTG, 32'hFF);
		i_cable.line(1'h0, 1'h0, 330);
		rd(A_BUS);
		check(rdata & 32'h01, 32'h0);
		i_cable.line(1'h1, 1'h0, 60);
		rd(A_OTG);
		check(rdata & 32'h60, 32'h60);
	endtask

	// watchdog well beyond the few thousand cycles the run needs
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end

	// main sequence: reset held five cycles, then each scenario in turn
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 16'h0;
		pwdata = 32'h0;
		low_speed = 1'h0;
		stall_sent = 1'h0;
		token_done = 1'h0;
		frame_start = 1'h0;
		err_events = 8'h0;
		err_total = 0;
		total_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_vbus();
		t_irq();
		t_bus();
		t_err();
		t_line();
		summarize();
	end
endmodule
